// File: hw/rlc_pkg.sv
// shared constants for the two-channel relay light on/off controller
// assumes a 100 MHz system clock and 16-bit word-addressed registers
package rlc_pkg;
  localparam logic [15:0] RLC_CH1_CTRL_ADDR = 16'h9D3E;
  localparam logic [15:0] RLC_CH2_CTRL_ADDR = 16'h9D3F;
  localparam int RLC_REG_W = 16;
  // control register field positions
  localparam int RLC_STATE_BIT = 0;
  localparam int RLC_ON_BIT = 1;
  localparam int RLC_OFF_BIT = 2;
  localparam int RLC_INHIBIT_BIT = 3;
  localparam int RLC_POL_BIT = 4;
  localparam int RLC_HOLD_LSB = 8;
  localparam int RLC_HOLD_W = 8;
  // reset values
  localparam logic RLC_INHIBIT_RESET = 1'b0;
  localparam logic RLC_POL_RESET = 1'b0;
  localparam logic [7:0] RLC_HOLD_RESET = 8'h3C;
  // timing
  localparam longint RLC_CLK_HZ = 100_000_000;
  localparam longint RLC_TICK_MS = 1000;
  localparam longint RLC_DEBOUNCE_MS = 10;
  localparam int RLC_TICK_CYCLES = int'((RLC_CLK_HZ / 1000) * RLC_TICK_MS);
  localparam int RLC_DEBOUNCE_CYCLES = int'((RLC_CLK_HZ / 1000) * RLC_DEBOUNCE_MS);
  // switch type as selected per channel
  typedef enum logic {RLC_SW_MOMENTARY, RLC_SW_LATCHING} rlc_switch_type_t;
endpackage

// File: hw/rlc_relay_light.sv
// two-channel relay on/off light controller: switches, occupancy sensors, lamp relays
// assumes raw pins and config switches are asynchronous; register port is on sys_clk
`timescale 1ns/1ns
`default_nettype none
module rlc_relay_light #(
  parameter int TICK_CYCLES = rlc_pkg::RLC_TICK_CYCLES,
  parameter int DEBOUNCE_CYCLES = rlc_pkg::RLC_DEBOUNCE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic relay_mode_sel,
  input wire logic group_switch_sel,
  input wire logic group_sensor_sel,
  input wire logic [1:0] switch_type_sel,
  input wire logic switch_input_one,
  input wire logic switch_input_two,
  input wire logic sensor_input_one,
  input wire logic sensor_input_two,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [rlc_pkg::RLC_REG_W-1:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [rlc_pkg::RLC_REG_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  output logic light_relay_one,
  output logic light_relay_two
);
  import rlc_pkg::*;

  localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [15:0] CH_ADDR [2] = '{RLC_CH1_CTRL_ADDR, RLC_CH2_CTRL_ADDR};

  // pin synchroniser
  logic [8:0] pin_raw;
  logic [8:0] pin_meta_reg;
  logic [8:0] pin_sync_reg;
  assign pin_raw = {switch_type_sel, group_sensor_sel, group_switch_sel, relay_mode_sel,
                    sensor_input_two, sensor_input_one, switch_input_two, switch_input_one};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= 9'h000;
      pin_sync_reg <= 9'h000;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic relay_mode;
  logic group_sw;
  logic group_sens;
  logic [1:0] latch_sel;
  assign relay_mode = pin_sync_reg[4];
  assign group_sw = pin_sync_reg[5];
  assign group_sens = pin_sync_reg[6];
  assign latch_sel = pin_sync_reg[8:7];

  // debounce of the two switches and two sensors
  logic [3:0] deb_reg;
  logic [3:0] deb_prev_reg;
  logic [DEB_W-1:0] deb_cnt_reg [4];
  // sensors rest at closed contact, so they start high
  localparam logic [3:0] DEB_RESET = 4'hC;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_deb
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          deb_reg[g] <= DEB_RESET[g];
          deb_cnt_reg[g] <= '0;
        end else if (pin_sync_reg[g] == deb_reg[g]) begin
          deb_cnt_reg[g] <= '0;
        end else if (deb_cnt_reg[g] == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
          deb_reg[g] <= pin_sync_reg[g];
          deb_cnt_reg[g] <= '0;
        end else begin
          deb_cnt_reg[g] <= deb_cnt_reg[g] + DEB_W'(1);
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      deb_prev_reg <= DEB_RESET;
    end else begin
      deb_prev_reg <= deb_reg;
    end
  end

  logic [3:0] deb_rise;
  logic [3:0] deb_fall;
  assign deb_rise = deb_reg & ~deb_prev_reg;
  assign deb_fall = ~deb_reg & deb_prev_reg;

  // seconds tick for the hold countdown
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end

  // per-channel configuration held in the control registers
  logic [1:0] inhibit_reg;
  logic [1:0] pol_reg;
  logic [RLC_HOLD_W-1:0] hold_time_reg [2];
  logic [1:0] on_cmd;
  logic [1:0] off_cmd;

  // channel state
  logic [1:0] state_reg;
  logic [1:0] sensor_on_reg;
  logic [1:0] override_reg;
  logic [RLC_HOLD_W-1:0] hold_cnt_reg [2];

  // routed events per channel
  logic [1:0] sw_rise;
  logic [1:0] sw_fall;
  logic [1:0] sw_act;
  logic [1:0] latching;
  logic [1:0] motion;
  logic [1:0] sensor_ok;
  logic grp_target;

  // in grouped momentary mode a press turns everything off if anything is on
  assign grp_target = ~|state_reg;

  generate
    for (g = 0; g < 2; g++) begin : g_ch
      localparam int SRC = g;
      logic sens_lvl;
      logic sens_pol;
      logic sw_sel_rise;
      logic sw_sel_fall;

      assign sw_sel_rise = group_sw ? deb_rise[0] : deb_rise[SRC];
      assign sw_sel_fall = group_sw ? deb_fall[0] : deb_fall[SRC];
      assign sens_lvl = group_sens ? deb_reg[2] : deb_reg[2 + SRC];
      assign sens_pol = group_sens ? pol_reg[0] : pol_reg[SRC];
      assign sw_rise[g] = sw_sel_rise;
      assign sw_fall[g] = sw_sel_fall;
      assign latching[g] = (group_sw ? latch_sel[0] : latch_sel[g]) == RLC_SW_LATCHING;
      // closed contact is idle unless polarity flipped to normally open
      assign motion[g] = ~(sens_lvl ^ sens_pol);
      assign sw_act[g] = relay_mode & (sw_rise[g] | (latching[g] & sw_fall[g]));
      assign sensor_ok[g] = relay_mode & ~inhibit_reg[g] & ~override_reg[g];
      assign on_cmd[g] = reg_wr_en & (reg_addr == CH_ADDR[g]) & reg_wdata[RLC_ON_BIT];
      assign off_cmd[g] = reg_wr_en & (reg_addr == CH_ADDR[g]) & reg_wdata[RLC_OFF_BIT];

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          inhibit_reg[g] <= RLC_INHIBIT_RESET;
          pol_reg[g] <= RLC_POL_RESET;
          hold_time_reg[g] <= RLC_HOLD_RESET;
        end else if (reg_wr_en && reg_addr == CH_ADDR[g]) begin
          inhibit_reg[g] <= reg_wdata[RLC_INHIBIT_BIT];
          pol_reg[g] <= reg_wdata[RLC_POL_BIT];
          hold_time_reg[g] <= reg_wdata[RLC_HOLD_LSB +: RLC_HOLD_W];
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          state_reg[g] <= 1'b0;
          sensor_on_reg[g] <= 1'b0;
          override_reg[g] <= 1'b0;
          hold_cnt_reg[g] <= '0;
        end else if (sw_act[g]) begin
          if (sensor_on_reg[g]) begin
            state_reg[g] <= 1'b0;
            sensor_on_reg[g] <= 1'b0;
            override_reg[g] <= 1'b1;
          end else begin
            override_reg[g] <= 1'b0;
            if (latching[g]) begin
              state_reg[g] <= sw_sel_rise;
            end else if (group_sw) begin
              state_reg[g] <= grp_target;
            end else begin
              state_reg[g] <= ~state_reg[g];
            end
          end
        end else if (on_cmd[g]) begin
          state_reg[g] <= 1'b1;
          sensor_on_reg[g] <= 1'b0;
        end else if (off_cmd[g]) begin
          state_reg[g] <= 1'b0;
          sensor_on_reg[g] <= 1'b0;
        end else if (sensor_ok[g] && motion[g]) begin
          if (!state_reg[g]) begin
            state_reg[g] <= 1'b1;
            sensor_on_reg[g] <= 1'b1;
            hold_cnt_reg[g] <= hold_time_reg[g];
          end else if (sensor_on_reg[g]) begin
            hold_cnt_reg[g] <= hold_time_reg[g];
          end
        end else if (relay_mode && sensor_on_reg[g] && tick) begin
          if (hold_cnt_reg[g] <= RLC_HOLD_W'(1)) begin
            state_reg[g] <= 1'b0;
            sensor_on_reg[g] <= 1'b0;
            hold_cnt_reg[g] <= '0;
          end else begin
            hold_cnt_reg[g] <= hold_cnt_reg[g] - RLC_HOLD_W'(1);
          end
        end
      end

      // assertions for this channel
      sequence s_expire;
        relay_mode && sensor_on_reg[g] && tick && hold_cnt_reg[g] == 8'h01 && !sw_act[g] && !on_cmd[g] &&
          !off_cmd[g] && !(sensor_ok[g] && motion[g]);
      endsequence

      sequence s_sensor_start;
        sensor_ok[g] && motion[g] && !state_reg[g] && !sw_act[g] && !on_cmd[g] && !off_cmd[g];
      endsequence

      a_relay_mode_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !relay_mode && !on_cmd[g] && !off_cmd[g] |=> state_reg[g] == $past(state_reg[g]) &&
          (relay_mode || !(g == 0 ? light_relay_one : light_relay_two)))
        else $error("relay driven outside relay mode");

      a_state_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == CH_ADDR[g] |=> reg_rd_valid && reg_rdata[RLC_STATE_BIT] == $past(state_reg[g]))
        else $error("state bit readback wrong");

      a_on_write_sets: assert property (@(posedge sys_clk) disable iff (!reset_n)
        on_cmd[g] && !sw_act[g] |=> state_reg[g] && !sensor_on_reg[g])
        else $error("on command did not set state");

      a_off_write_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
        off_cmd[g] && !on_cmd[g] && !sw_act[g] |=> !state_reg[g])
        else $error("off command did not clear state");

      a_momentary_toggle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sw_act[g] && !latching[g] && !group_sw && !sensor_on_reg[g] |=> state_reg[g] != $past(state_reg[g]))
        else $error("momentary press did not toggle");

      a_latch_follows: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sw_act[g] && latching[g] && !sensor_on_reg[g] |=> state_reg[g] == $past(sw_rise[g]))
        else $error("latching edge gave wrong state");

      a_sensor_turn_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_sensor_start |=> state_reg[g] && sensor_on_reg[g] && hold_cnt_reg[g] == $past(hold_time_reg[g]))
        else $error("motion did not switch on");

      a_hold_expire: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_expire |=> !state_reg[g] && !sensor_on_reg[g])
        else $error("hold expiry did not switch off");

      a_override_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sw_act[g] && sensor_on_reg[g] |=> !state_reg[g] && override_reg[g])
        else $error("switch did not override sensor");

      a_inhibit_blocks: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (inhibit_reg[g] || override_reg[g]) && !state_reg[g] && !sw_act[g] && !on_cmd[g] |=> !state_reg[g])
        else $error("blocked sensor switched light on");

      // motion on a sensor-lit channel restarts the hold time every cycle
      a_motion_reload: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sensor_ok[g] && motion[g] && state_reg[g] && sensor_on_reg[g] && !sw_act[g] && !on_cmd[g] &&
          !off_cmd[g] |=> hold_cnt_reg[g] == $past(hold_time_reg[g]))
        else $error("motion did not reload hold time");
    end
  endgenerate

  // lamps are plain on/off contacts; no level control exists here
  assign light_relay_one = relay_mode & state_reg[0];
  assign light_relay_two = relay_mode & state_reg[1];

  // register read port
  logic [RLC_REG_W-1:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (reg_addr == RLC_CH1_CTRL_ADDR) begin
      rd_word[RLC_STATE_BIT] = state_reg[0];
      rd_word[RLC_INHIBIT_BIT] = inhibit_reg[0];
      rd_word[RLC_POL_BIT] = pol_reg[0];
      rd_word[RLC_HOLD_LSB +: RLC_HOLD_W] = hold_time_reg[0];
    end else if (reg_addr == RLC_CH2_CTRL_ADDR) begin
      rd_word[RLC_STATE_BIT] = state_reg[1];
      rd_word[RLC_INHIBIT_BIT] = inhibit_reg[1];
      rd_word[RLC_POL_BIT] = pol_reg[1];
      rd_word[RLC_HOLD_LSB +: RLC_HOLD_W] = hold_time_reg[1];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rd_word;
      end
    end
  end

  a_group_off_active: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sw_act[0] && group_sw && !latching[0] && (|state_reg) && !(|sensor_on_reg) |=> state_reg == 2'b00)
    else $error("grouped press left an output on");

  a_group_on_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sw_act[0] && group_sw && !latching[0] && !(|state_reg) && !(|sensor_on_reg) |=> state_reg == 2'b11)
    else $error("grouped press did not switch both on");

  a_group_motion: assert property (@(posedge sys_clk) disable iff (!reset_n)
    group_sens && relay_mode && override_reg[1] && !state_reg[1] && !sw_act[1] && !on_cmd[1] |=> !state_reg[1])
    else $error("grouped motion hit overridden output");
endmodule // rlc_relay_light
`default_nettype wire

// File: tb/rlc_field_model.sv
// field model: two wall switches, two occupancy sensors, two lamp loads
// assumes the bench calls its tasks; pins change on the falling edge of sys_clk
`timescale 1ns/1ns
`default_nettype none
module rlc_field_model (
  input wire logic sys_clk,
  input wire logic light_relay_one,
  input wire logic light_relay_two,
  output var logic switch_input_one,
  output var logic switch_input_two,
  output var logic sensor_input_one,
  output var logic sensor_input_two,
  output logic [1:0] lamp_lit
);
  // switches idle open, normally closed sensor contacts idle closed
  initial begin
    switch_input_one = 1'b0;
    switch_input_two = 1'b0;
    sensor_input_one = 1'b1;
    sensor_input_two = 1'b1;
  end
  assign lamp_lit = {light_relay_one, light_relay_two};
  task automatic set_sw(input int ch, input logic v);
    @(negedge sys_clk);
    if (ch == 1) switch_input_one = v;
    else switch_input_two = v;
  endtask
  task automatic set_sn(input int ch, input logic v);
    @(negedge sys_clk);
    if (ch == 1) sensor_input_one = v;
    else sensor_input_two = v;
  endtask
endmodule // rlc_field_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the relay light controller
// assumes rlc_field_model on the pins and short tick and debounce counts
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import rlc_pkg::*;
  localparam int TICK = 20;
  localparam int DEB = 4;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mode = 1'b1;
  logic grp_sw = 1'b0;
  logic grp_sn = 1'b0;
  logic [1:0] sw_type = 2'b00;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_rdata;
  logic reg_rd_valid;
  logic relay1, relay2, sw1, sw2, sn1, sn2;
  logic [1:0] lit;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  rlc_relay_light #(.TICK_CYCLES(TICK), .DEBOUNCE_CYCLES(DEB)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .relay_mode_sel(mode), .group_switch_sel(grp_sw), .group_sensor_sel(grp_sn), .switch_type_sel(sw_type),
    .switch_input_one(sw1), .switch_input_two(sw2), .sensor_input_one(sn1), .sensor_input_two(sn2),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .light_relay_one(relay1), .light_relay_two(relay2));
  rlc_field_model FM (.sys_clk(sys_clk), .light_relay_one(relay1), .light_relay_two(relay2),
    .switch_input_one(sw1), .switch_input_two(sw2), .sensor_input_one(sn1), .sensor_input_two(sn2),
    .lamp_lit(lit));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // cuts a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    `CHK(reg_rd_valid, 1'b1)
    `CHK(reg_rdata, e)
  endtask
  task automatic lamps(input logic a, input logic b);
    logic [1:0] want;
    want = {a, b};
    idle(1);
    `CHK(lit, want)
  endtask
  // pin change plus sync, debounce and relay latency margin
  task automatic sw(input int ch, input logic v);
    FM.set_sw(ch, v);
    idle(12);
  endtask
  task automatic sn(input int ch, input logic v);
    FM.set_sn(ch, v);
    idle(12);
  endtask
  task automatic press(input int ch);
    sw(ch, 1'b1);
    sw(ch, 1'b0);
  endtask
  initial begin
    idle(4);
    reset_n = 1'b1;
    rd(RLC_CH1_CTRL_ADDR, 16'h3C00);
    rd(RLC_CH2_CTRL_ADDR, 16'h3C00);
    rd(16'h9D40, 16'h0000);
    wr(RLC_CH1_CTRL_ADDR, 16'h0302);
    lamps(1, 0);
    rd(RLC_CH1_CTRL_ADDR, 16'h0301);
    wr(RLC_CH1_CTRL_ADDR, 16'h0304);
    lamps(0, 0);
    sw(1, 1'b1);
    idle(30);
    lamps(1, 0);
    sw(1, 1'b0);
    lamps(1, 0);
    press(1);
    lamps(0, 0);
    FM.set_sw(1, 1'b1);
    FM.set_sw(1, 1'b0);
    idle(12);
    lamps(0, 0);
    sw_type = 2'b10;
    sw(2, 1'b1);
    lamps(0, 1);
    sw(2, 1'b0);
    lamps(0, 0);
    sw_type = 2'b00;
    // motion on a normally closed contact opens it
    sn(1, 1'b0);
    lamps(1, 0);
    sn(1, 1'b1);
    idle(25);
    lamps(1, 0);
    sn(1, 1'b0);
    sn(1, 1'b1);
    idle(25);
    lamps(1, 0);
    idle(45);
    lamps(0, 0);
    sn(1, 1'b0);
    sn(1, 1'b1);
    press(1);
    lamps(0, 0);
    sn(1, 1'b0);
    lamps(0, 0);
    sn(1, 1'b1);
    press(1);
    lamps(1, 0);
    press(1);
    sn(1, 1'b0);
    lamps(1, 0);
    sn(1, 1'b1);
    idle(82);
    lamps(0, 0);
    wr(RLC_CH1_CTRL_ADDR, 16'h0308);
    sn(1, 1'b0);
    lamps(0, 0);
    sn(1, 1'b1);
    rd(RLC_CH1_CTRL_ADDR, 16'h0308);
    // normally open: the idle-high pin now reads as motion
    wr(RLC_CH1_CTRL_ADDR, 16'h0310);
    idle(3);
    lamps(1, 0);
    sn(1, 1'b0);
    idle(82);
    lamps(0, 0);
    wr(RLC_CH1_CTRL_ADDR, 16'h0318);
    sn(1, 1'b1);
    wr(RLC_CH1_CTRL_ADDR, 16'h0300);
    mode = 1'b0;
    wr(RLC_CH2_CTRL_ADDR, 16'h0302);
    lamps(0, 0);
    press(2);
    rd(RLC_CH2_CTRL_ADDR, 16'h0301);
    mode = 1'b1;
    idle(4);
    lamps(0, 1);
    wr(RLC_CH2_CTRL_ADDR, 16'h0304);
    grp_sw = 1'b1;
    press(1);
    lamps(1, 1);
    wr(RLC_CH2_CTRL_ADDR, 16'h0304);
    press(1);
    lamps(0, 0);
    grp_sw = 1'b0;
    grp_sn = 1'b1;
    wr(RLC_CH2_CTRL_ADDR, 16'h0302);
    sn(1, 1'b0);
    lamps(1, 1);
    sn(1, 1'b1);
    idle(82);
    lamps(0, 1);
    // grouped sensor lights both, then a switch overrides output two only
    wr(RLC_CH2_CTRL_ADDR, 16'h0304);
    sn(1, 1'b0);
    lamps(1, 1);
    press(2);
    lamps(1, 0);
    sn(1, 1'b1);
    sn(1, 1'b0);
    lamps(1, 0);
    sn(1, 1'b1);
    idle(82);
    lamps(0, 0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
